// [clkgen_params.svh]
// constants for the clock generating and standby control block
`ifndef CLKGEN_PARAMS_SVH
`define CLKGEN_PARAMS_SVH
// register indices on the register port
`define CLKGEN_ADDR_CMR 8'h00
`define CLKGEN_ADDR_CPUM 8'h01
`define CLKGEN_ADDR_OSCC 8'h02
`define CLKGEN_ADDR_PRE 8'h03
`define CLKGEN_ADDR_T1 8'h04
`define CLKGEN_ADDR_PDAT 8'h05
`define CLKGEN_ADDR_PDIR 8'h06
`define CLKGEN_ADDR_STAT 8'h07
// clock_mode_reg fields
`define CLKGEN_CMR_LS_STOP 0
`define CLKGEN_CMR_HS_STOP 1
`define CLKGEN_CMR_SRC_LO 4
`define CLKGEN_CMR_SPD_LO 6
`define CLKGEN_CMR_RST 8'h02
// oscillation control register fields
`define CLKGEN_OSCC_XSTOP 0
`define CLKGEN_OSCC_STAB 1
`define CLKGEN_OSCC_PSUB 2
`define CLKGEN_OSCC_RST 8'h00
// option word fields
`define CLKGEN_FO1_METH_LO 0
`define CLKGEN_FO2_LSLOCK 4
// oscillation method codes
`define CLKGEN_METH_NONE 2'h0
`define CLKGEN_METH_MAIN 2'h1
`define CLKGEN_METH_SUB 2'h2
`define CLKGEN_METH_EXT 2'h3
// timer values
`define CLKGEN_T1_PRESET 8'h01
`define CLKGEN_PRE_PRESET 8'hFF
`define CLKGEN_DIV16 4'hF
`endif

// [clkgen_pkg.sv]
// types shared by the clock generating block
package clkgen_pkg;
  typedef enum logic [2:0] {
    CG_RUN, CG_STOP_PEND, CG_STOPPED, CG_STAB, CG_WAIT_PEND, CG_WAITING
  } clkgen_state_t;
  // clock source select: 0 low-speed, 1 main, 2 sub, 3 high-speed
  typedef logic [1:0] clkgen_src_t;
endpackage : clkgen_pkg

// [clkgen_tmr.sv]
// timer 1 and its shared prescaler, used as stop-release stabiliser
`timescale 1ns/1ps
`include "clkgen_params.svh"
module clkgen_tmr (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic cnt_tick_i,
  input wire logic pre_wr_i,
  input wire logic t1_wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic stop_preset_i,
  output logic [7:0] pre_cnt_o,
  output logic [7:0] t1_cnt_o,
  output logic t1_unf_o
);
  import clkgen_pkg::*;

  logic [7:0] pre_lat_r;
  logic [7:0] t1_lat_r;
  logic pre_unf;

  assign pre_unf = cnt_tick_i && (pre_cnt_o == 8'h00);

  // latches: a write loads latch and counter together
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pre_lat_r <= `CLKGEN_PRE_PRESET;
      t1_lat_r <= `CLKGEN_T1_PRESET;
    end else begin
      if (pre_wr_i) pre_lat_r <= wdata_i;
      if (t1_wr_i) t1_lat_r <= wdata_i;
    end
  end

  // prescaler: zero then one more pulse underflows and reloads
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pre_cnt_o <= `CLKGEN_PRE_PRESET;
    end else if (stop_preset_i) begin
      pre_cnt_o <= `CLKGEN_PRE_PRESET;
    end else if (pre_wr_i) begin
      pre_cnt_o <= wdata_i;
    end else if (pre_unf) begin
      pre_cnt_o <= pre_lat_r;
    end else if (cnt_tick_i) begin
      pre_cnt_o <= pre_cnt_o - 8'h01;
    end
  end

  // timer 1 counts prescaler underflows, pulses on its own underflow
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      t1_cnt_o <= `CLKGEN_T1_PRESET;
      t1_unf_o <= 1'b0;
    end else begin
      t1_unf_o <= 1'b0;
      if (stop_preset_i) begin
        t1_cnt_o <= `CLKGEN_T1_PRESET;
      end else if (t1_wr_i) begin
        t1_cnt_o <= wdata_i;
      end else if (pre_unf && (t1_cnt_o == 8'h00)) begin
        t1_cnt_o <= t1_lat_r;
        t1_unf_o <= 1'b1;
      end else if (pre_unf) begin
        t1_cnt_o <= t1_cnt_o - 8'h01;
      end
    end
  end
endmodule : clkgen_tmr

// [clkgen_core.sv]
// clock source selection, divider, stop and wait gating, shared pins
`timescale 1ns/1ps
`include "clkgen_params.svh"
module clkgen_core (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] factory_option_word_1_i,
  input wire logic [7:0] factory_option_word_2_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic halt_oscillator_instruction_i,
  input wire logic clock_gate_instruction_i,
  input wire logic wake_irq_i,
  input wire logic main_osc_tick_i,
  input wire logic sub_osc_tick_i,
  input wire logic hs_osc_tick_i,
  input wire logic ls_osc_tick_i,
  output logic main_osc_en_o,
  output logic sub_osc_en_o,
  output logic hs_osc_en_o,
  output logic ls_osc_en_o,
  input wire logic shared_pin_in_side_i,
  output logic shared_pin_in_side_o,
  output logic shared_pin_in_side_oe_o,
  output logic shared_pin_out_side_o,
  output logic shared_pin_out_side_oe_o,
  output logic phi_o,
  output logic phi_halted_o,
  output clkgen_pkg::clkgen_src_t cur_src_o
);
  import clkgen_pkg::*;

  // option words and their fields
  logic [7:0] fo1_r;
  logic [7:0] fo2_r;
  logic [1:0] meth;
  logic ls_lock;

  // software registers
  logic [7:0] clock_mode_reg_r;
  logic [7:0] oscc_r;
  logic [1:0] proc_mode_r;
  logic proc_lock_r;
  logic [1:0] pdat_r;
  logic pdir_r;

  // standby control
  clkgen_state_t state_r;
  logic osc_off;

  // divider and selection
  clkgen_src_t sel_src;
  logic [1:0] spd_r;
  logic [2:0] div_cnt_r;
  logic [3:0] div16_r;
  logic src_tick;
  logic main_run;
  logic sub_run;
  logic hs_run;
  logic ls_run;
  logic hold;
  logic phase_end;

  // timer link
  logic pre_tick;
  logic stop_preset;
  logic [7:0] pre_cnt;
  logic [7:0] t1_cnt;
  logic t1_unf;

  // per-register write strobes
  logic cmr_wr;
  logic oscc_wr;
  logic cpum_wr;
  logic pdat_wr;
  logic pdir_wr;
  logic pre_wr;
  logic t1_wr;

  // half-period count for each speed: 1, 2, 4, 8 source edges
  function automatic logic [2:0] half_len(input logic [1:0] spd);
    case (spd)
      2'h0: half_len = 3'h0;
      2'h1: half_len = 3'h1;
      2'h2: half_len = 3'h3;
      default: half_len = 3'h7;
    endcase
  endfunction : half_len

  // one index compare shared by every write strobe
  function automatic logic reg_hit(input logic stb, input logic [7:0] addr,
                                   input logic [7:0] idx);
    reg_hit = stb && (addr == idx);
  endfunction : reg_hit

  // write strobes decoded in one place, so no register sees a stray match
  assign cmr_wr = reg_hit(reg_wr_i, reg_addr_i, `CLKGEN_ADDR_CMR);
  assign oscc_wr = reg_hit(reg_wr_i, reg_addr_i, `CLKGEN_ADDR_OSCC);
  assign cpum_wr = reg_hit(reg_wr_i, reg_addr_i, `CLKGEN_ADDR_CPUM);
  assign pdat_wr = reg_hit(reg_wr_i, reg_addr_i, `CLKGEN_ADDR_PDAT);
  assign pdir_wr = reg_hit(reg_wr_i, reg_addr_i, `CLKGEN_ADDR_PDIR);
  assign pre_wr = reg_hit(reg_wr_i, reg_addr_i, `CLKGEN_ADDR_PRE);
  assign t1_wr = reg_hit(reg_wr_i, reg_addr_i, `CLKGEN_ADDR_T1);

  assign meth = fo1_r[`CLKGEN_FO1_METH_LO +: 2];
  assign ls_lock = !fo2_r[`CLKGEN_FO2_LSLOCK];
  assign sel_src = clock_mode_reg_r[`CLKGEN_CMR_SRC_LO +: 2];

  // option words are caught while reset is held, stable afterwards
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      fo1_r <= factory_option_word_1_i;
      fo2_r <= factory_option_word_2_i;
    end
  end

  // clock mode register; low-speed stop bit cannot rise when locked
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      clock_mode_reg_r <= `CLKGEN_CMR_RST;
    end else if (cmr_wr) begin
      clock_mode_reg_r <= reg_wdata_i;
      if (ls_lock) begin
        clock_mode_reg_r[`CLKGEN_CMR_LS_STOP] <= 1'b0;
      end
    end
  end

  // oscillation control: resonator stop, stabilise skip, prescaler src
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      oscc_r <= `CLKGEN_OSCC_RST;
    end else if (oscc_wr) begin
      oscc_r <= reg_wdata_i;
    end
  end

  // processor mode bits take only the first write after reset
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      proc_mode_r <= 2'h0;
      proc_lock_r <= 1'b0;
    end else if (cpum_wr && !proc_lock_r) begin
      proc_mode_r <= reg_wdata_i[1:0];
      proc_lock_r <= 1'b1;
    end
  end

  // port data and in-side direction for the shared pins
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pdat_r <= 2'h0;
      pdir_r <= 1'b0;
    end else if (pdat_wr) begin
      pdat_r <= reg_wdata_i[1:0];
    end else if (pdir_wr) begin
      pdir_r <= reg_wdata_i[1];
    end
  end

  // standby sequencer: halt only once the clock sits high
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_r <= CG_RUN;
    end else begin
      case (state_r)
        CG_RUN: begin
          if (halt_oscillator_instruction_i) begin
            state_r <= CG_STOP_PEND;
          end else if (clock_gate_instruction_i) begin
            state_r <= CG_WAIT_PEND;
          end
        end
        CG_STOP_PEND: begin
          if (phi_o) state_r <= CG_STOPPED;
        end
        CG_STOPPED: begin
          // wake interrupt restarts oscillators but not the clock
          if (wake_irq_i) state_r <= CG_STAB;
        end
        CG_STAB: begin
          if (t1_unf) state_r <= CG_RUN;
        end
        CG_WAIT_PEND: begin
          if (phi_o) state_r <= CG_WAITING;
        end
        CG_WAITING: begin
          if (wake_irq_i) state_r <= CG_RUN;
        end
        default: state_r <= CG_RUN;
      endcase
    end
  end

  // timer preset pulses once on entry to stop unless software opted out
  assign stop_preset = (state_r == CG_STOP_PEND) && phi_o && !oscc_r[`CLKGEN_OSCC_STAB];
  assign osc_off = (state_r == CG_STOPPED);

  // oscillator run conditions per method and control bits
  assign main_run = ((meth == `CLKGEN_METH_MAIN) || (meth == `CLKGEN_METH_EXT))
                    && !oscc_r[`CLKGEN_OSCC_XSTOP] && !osc_off;
  assign sub_run = (meth == `CLKGEN_METH_SUB)
                   && !oscc_r[`CLKGEN_OSCC_XSTOP] && !osc_off;
  assign hs_run = !clock_mode_reg_r[`CLKGEN_CMR_HS_STOP] && !osc_off;
  assign ls_run = ls_lock || (!clock_mode_reg_r[`CLKGEN_CMR_LS_STOP] && !osc_off);

  // oscillator enables are registered so each output is a flop
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      main_osc_en_o <= 1'b0;
      sub_osc_en_o <= 1'b0;
      hs_osc_en_o <= 1'b0;
      ls_osc_en_o <= 1'b1;
    end else begin
      main_osc_en_o <= main_run && (meth == `CLKGEN_METH_MAIN);
      sub_osc_en_o <= sub_run;
      hs_osc_en_o <= hs_run;
      ls_osc_en_o <= ls_run;
    end
  end

  // edge of the active source; a stopped oscillator gives no edges
  always_comb begin
    case (cur_src_o)
      2'h1: src_tick = main_osc_tick_i && main_run;
      2'h2: src_tick = sub_osc_tick_i && sub_run;
      2'h3: src_tick = hs_osc_tick_i && hs_run;
      default: src_tick = ls_osc_tick_i && ls_run;
    endcase
  end

  // the clock freezes high in every state but run
  assign hold = (state_r != CG_RUN) && phi_o;
  assign phase_end = src_tick && (div_cnt_r == half_len(spd_r));

  // divider: count source edges per half period
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      div_cnt_r <= 3'h0;
    end else if (hold) begin
      div_cnt_r <= 3'h0;
    end else if (phase_end) begin
      div_cnt_r <= 3'h0;
    end else if (src_tick) begin
      div_cnt_r <= div_cnt_r + 3'h1;
    end
  end

  // internal clock level; toggles only at a finished half period
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      phi_o <= 1'b1;
    end else if (phase_end && !hold) begin
      phi_o <= !phi_o;
    end
  end

  // source and speed change as a low phase ends or while the clock is held, so no runt phase
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cur_src_o <= 2'h0;
      spd_r <= 2'h0;
    end else if ((phase_end && !hold && !phi_o) || (hold && (state_r != CG_RUN))) begin
      cur_src_o <= sel_src;
      spd_r <= clock_mode_reg_r[`CLKGEN_CMR_SPD_LO +: 2];
    end
  end

  // halted flag for status and the outside world
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      phi_halted_o <= 1'b0;
    end else begin
      phi_halted_o <= hold;
    end
  end

  // source divided by sixteen; keeps running during stabilisation
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      div16_r <= 4'h0;
    end else if (src_tick) begin
      div16_r <= div16_r + 4'h1;
    end
  end

  // prescaler source: sub clock only allowed with the 32 kHz method
  always_comb begin
    if (oscc_r[`CLKGEN_OSCC_PSUB] && (meth == `CLKGEN_METH_SUB)) begin
      pre_tick = sub_osc_tick_i && sub_run;
    end else begin
      pre_tick = src_tick && (div16_r == `CLKGEN_DIV16);
    end
  end

  clkgen_tmr u_tmr (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .cnt_tick_i(pre_tick),
    .pre_wr_i(pre_wr),
    .t1_wr_i(t1_wr),
    .wdata_i(reg_wdata_i),
    .stop_preset_i(stop_preset),
    .pre_cnt_o(pre_cnt),
    .t1_cnt_o(t1_cnt),
    .t1_unf_o(t1_unf)
  );

  // shared pins: ports only where no oscillator uses them
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      shared_pin_out_side_o <= 1'b0;
      shared_pin_out_side_oe_o <= 1'b0;
      shared_pin_in_side_o <= 1'b0;
      shared_pin_in_side_oe_o <= 1'b0;
    end else begin
      shared_pin_out_side_o <= pdat_r[0];
      shared_pin_out_side_oe_o <= (meth == `CLKGEN_METH_NONE);
      shared_pin_in_side_o <= pdat_r[1];
      shared_pin_in_side_oe_o <= pdir_r && ((meth == `CLKGEN_METH_NONE)
                                 || (meth == `CLKGEN_METH_EXT));
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_addr_i == `CLKGEN_ADDR_CMR) begin
      reg_rdata_o <= clock_mode_reg_r;
    end else if (reg_addr_i == `CLKGEN_ADDR_CPUM) begin
      reg_rdata_o <= {5'h00, proc_lock_r, proc_mode_r};
    end else if (reg_addr_i == `CLKGEN_ADDR_OSCC) begin
      reg_rdata_o <= {5'h00, oscc_r[2:0]};
    end else if (reg_addr_i == `CLKGEN_ADDR_PRE) begin
      reg_rdata_o <= pre_cnt;
    end else if (reg_addr_i == `CLKGEN_ADDR_T1) begin
      reg_rdata_o <= t1_cnt;
    end else if (reg_addr_i == `CLKGEN_ADDR_PDAT) begin
      reg_rdata_o <= {6'h00, pdat_r};
    end else if (reg_addr_i == `CLKGEN_ADDR_PDIR) begin
      reg_rdata_o <= {6'h00, pdir_r, 1'b0};
    end else if (reg_addr_i == `CLKGEN_ADDR_STAT) begin
      // status: pin level, method, source, halted
      reg_rdata_o <= {shared_pin_in_side_i, meth, cur_src_o, phi_halted_o, phi_o, ls_run};
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end
endmodule : clkgen_core

// [clkgen_osc_model.sv]
// behavioural oscillators that give one tick per source half period
`timescale 1ns/1ps
module clkgen_osc_model #(
  parameter int HP_MAIN = 4,
  parameter int HP_SUB = 6,
  parameter int HP_HS = 3,
  parameter int HP_LS = 2
) (
  input wire logic core_clk_i,
  input wire logic [3:0] osc_en_i,
  output logic [3:0] osc_tick_o
);
  localparam int HP [4] = '{HP_MAIN, HP_SUB, HP_HS, HP_LS};
  int cnt [4];
  initial osc_tick_o = 4'h0;
  // disabled oscillator stands still and restarts cold, so no stale ticks
  always @(posedge core_clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (!osc_en_i[i]) begin
        cnt[i] <= 0;
        osc_tick_o[i] <= 1'b0;
      end else begin
        osc_tick_o[i] <= (cnt[i] == HP[i] - 1);
        cnt[i] <= (cnt[i] == HP[i] - 1) ? 0 : cnt[i] + 1;
      end
    end
  end
endmodule : clkgen_osc_model

// [clkgen_core_props.sv]
// port-level assertions for the clock generating core
`timescale 1ns/1ps
module clkgen_core_props (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] factory_option_word_1_i,
  input wire logic [7:0] factory_option_word_2_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic halt_oscillator_instruction_i,
  input wire logic clock_gate_instruction_i,
  input wire logic wake_irq_i,
  input wire logic main_osc_en_o,
  input wire logic sub_osc_en_o,
  input wire logic hs_osc_en_o,
  input wire logic ls_osc_en_o,
  input wire logic phi_o,
  input wire logic phi_halted_o,
  input wire clkgen_pkg::clkgen_src_t cur_src_o
);
  import clkgen_pkg::*;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  logic wait_mode_r;
  // which instruction parked the clock; wake latency differs a lot
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) wait_mode_r <= 1'b0;
    else if (clock_gate_instruction_i) wait_mode_r <= 1'b1;
    else if (halt_oscillator_instruction_i) wait_mode_r <= 1'b0;
  end
  a_reset_state: assert property ($rose(rstn_i) |->
    phi_o && !phi_halted_o && cur_src_o == 2'h0 && ls_osc_en_o && !hs_osc_en_o)
    else $error("state after reset release wrong");
  a_halt_high: assert property (phi_halted_o |-> phi_o)
    else $error("clock parked low");
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read slot");
  a_ls_lock: assert property (!factory_option_word_2_i[4] |-> ls_osc_en_o)
    else $error("locked low-speed oscillator stopped");
  a_osc_method: assert property ((main_osc_en_o || sub_osc_en_o) |->
    factory_option_word_1_i[1:0] == (main_osc_en_o ? 2'h1 : 2'h2))
    else $error("resonator runs under wrong method");
  a_halt_entry: assert property ((clock_gate_instruction_i ||
    halt_oscillator_instruction_i) && !phi_halted_o |-> ##[1:1000] phi_halted_o)
    else $error("clock never parked");
  a_wait_release: assert property (wait_mode_r && phi_halted_o && wake_irq_i
    |-> ##[1:3] !phi_halted_o)
    else $error("wait not released promptly");
  a_stop_osc_off: assert property ($rose(phi_halted_o) && !wait_mode_r |->
    ##[0:1] (!main_osc_en_o && !sub_osc_en_o && !hs_osc_en_o
    && ls_osc_en_o == !factory_option_word_2_i[4]))
    else $error("oscillator left running in stop");
endmodule : clkgen_core_props
bind clkgen_core clkgen_core_props u_props (.core_clk_i, .rstn_i,
  .factory_option_word_1_i, .factory_option_word_2_i, .reg_rd_i, .reg_rdata_o,
  .halt_oscillator_instruction_i, .clock_gate_instruction_i, .wake_irq_i,
  .main_osc_en_o, .sub_osc_en_o, .hs_osc_en_o, .ls_osc_en_o, .phi_o,
  .phi_halted_o, .cur_src_o);

// [tb_top.sv]
// self-checking bench for the clock generating core
`timescale 1ns/1ps
module tb_top;
  import clkgen_pkg::*;
  localparam int LS_HP = 2;
  localparam int HS_HP = 3;
  localparam logic [7:0] RD_ADDR [6] = '{8'h03, 8'h04, 8'h00, 8'h02, 8'h01, 8'h08};
  localparam logic [7:0] RD_EXP [6] = '{8'hFF, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00};
  logic core_clk, rstn, wr, rd, halt_ins, gate_ins, wake, pin_in;
  logic [7:0] fo1, fo2, addr, wdata, rdata;
  logic [3:0] ens, ticks;
  logic pin_in_o, pin_in_oe, pin_out, pin_out_oe, phi, halted;
  clkgen_src_t cur_src;
  int n_fail = 0;
  int checks_done = 0;
  clkgen_core uut (.core_clk_i(core_clk), .rstn_i(rstn), .factory_option_word_1_i(fo1),
    .factory_option_word_2_i(fo2), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .halt_oscillator_instruction_i(halt_ins), .clock_gate_instruction_i(gate_ins),
    .wake_irq_i(wake), .main_osc_tick_i(ticks[0]), .sub_osc_tick_i(ticks[1]),
    .hs_osc_tick_i(ticks[2]), .ls_osc_tick_i(ticks[3]), .main_osc_en_o(ens[0]),
    .sub_osc_en_o(ens[1]), .hs_osc_en_o(ens[2]), .ls_osc_en_o(ens[3]),
    .shared_pin_in_side_i(pin_in), .shared_pin_in_side_o(pin_in_o),
    .shared_pin_in_side_oe_o(pin_in_oe), .shared_pin_out_side_o(pin_out),
    .shared_pin_out_side_oe_o(pin_out_oe), .phi_o(phi), .phi_halted_o(halted),
    .cur_src_o(cur_src));
  clkgen_osc_model #(.HP_HS(HS_HP), .HP_LS(LS_HP)) u_osc (.core_clk_i(core_clk),
    .osc_en_i(ens), .osc_tick_o(ticks));
  // 125 MHz system clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  function automatic int exp_period(input int spd, input int hp);
    return 2 * hp * (1 << spd);
  endfunction : exp_period
  // prescaler ff and timer 01 give 256 * 2 pulses of source/16
  function automatic int stab_cycles(input int hp);
    return 256 * 2 * 16 * hp;
  endfunction : stab_cycles
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      n_fail++;
    end
  endtask : chk
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd
  // option words only count while reset is low; hold it the full 20 cycles
  task automatic dut_reset(input logic [7:0] o1, input logic [7:0] o2);
    @(posedge core_clk);
    rstn <= 1'b0;
    fo1 <= o1;
    fo2 <= o2;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
  endtask : dut_reset
  // k: 0 stop, 1 wait, 2 wake
  task automatic pulse(input int k);
    @(posedge core_clk);
    halt_ins <= (k == 0);
    gate_ins <= (k == 1);
    wake <= (k == 2);
    @(posedge core_clk);
    halt_ins <= 1'b0;
    gate_ins <= 1'b0;
    wake <= 1'b0;
    #1;
  endtask : pulse
  task automatic wait_halt(input logic lvl, input int lim, output int n);
    n = 0;
    while (halted !== lvl && n < lim) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask : wait_halt
  // first two rises are skipped: new speed only lands on a rise
  task automatic phi_period(output int p);
    logic prev;
    for (int k = 0; k < 3; k++) begin
      p = 0;
      do begin
        prev = phi;
        @(posedge core_clk);
        #1;
        p++;
      end while (!(phi && !prev) && p < 400);
    end
  endtask : phi_period
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // watchdog well beyond the expected 17.5k cycles
  initial begin
    repeat (80000) @(posedge core_clk);
    n_fail++;
    print_verdict();
  end
  initial begin
    logic [7:0] d, st;
    int n;
    {rstn, wr, rd, halt_ins, gate_ins, wake, pin_in} = 7'h00;
    {fo1, fo2, addr, wdata} = 32'h0;
    void'($urandom(32'h8505));
    dut_reset(8'h00, 8'h00);
    for (int i = 0; i < 6; i++) begin
      reg_rd(RD_ADDR[i], d);
      chk("reset read", RD_EXP[i], d);
    end
    reg_wr(8'h01, 8'h00);
    reg_wr(8'h01, 8'h03);
    reg_rd(8'h01, d);
    chk("mode lock", 8'h04, d);
    reg_wr(8'h00, 8'h03);
    reg_rd(8'h00, d);
    chk("ls lock bit", 8'h02, d);
    chk("ls lock run", 1'b1, ens[3]);
    end_test("reset");
    for (int m = 0; m < 4; m++) begin
      dut_reset(8'(m), 8'h10);
      reg_wr(8'h06, 8'h02);
      for (int k = 0; k < 6; k++) begin
        d = 8'($urandom);
        reg_wr(8'h05, {6'h00, d[1:0]});
        pin_in <= d[2];
        repeat (2) @(posedge core_clk);
        #1;
        chk("main en", m == 1, ens[0]);
        chk("sub en", m == 2, ens[1]);
        chk("out oe", m == 0, pin_out_oe);
        chk("in oe", m == 0 || m == 3, pin_in_oe);
        if (m == 0) chk("out level", d[0], pin_out);
        if (m == 0 || m == 3) chk("in level", d[1], pin_in_o);
        reg_rd(8'h07, st);
        chk("status", {d[2], 2'(m)}, st[7:5]);
      end
      // sub clock may feed the prescaler only under the 32 kHz method
      reg_wr(8'h02, 8'h04);
      reg_wr(8'h03, 8'hFF);
      repeat (96) @(posedge core_clk);
      reg_rd(8'h03, d);
      chk("sub prescale", m == 2, (8'hFF - d) > 8'h0A);
      // resonator control bit set stops main and sub amplifiers
      reg_wr(8'h02, 8'h05);
      repeat (2) @(posedge core_clk);
      #1;
      chk("resonator stop", 2'h0, ens[1:0]);
    end
    end_test("methods");
    dut_reset(8'h00, 8'h10);
    for (int s = 0; s < 4; s++) begin
      reg_wr(8'h00, {2'(s), 6'h02});
      phi_period(n);
      chk("ls period", exp_period(s, LS_HP), n);
    end
    reg_wr(8'h00, 8'h30);
    phi_period(n);
    chk("hs period", exp_period(0, HS_HP), n);
    chk("hs source", 2'h3, cur_src);
    reg_wr(8'h00, 8'h31);
    reg_rd(8'h00, d);
    chk("ls stop bit", 8'h31, d);
    chk("ls stopped", 1'b0, ens[3]);
    reg_wr(8'h00, 8'h00);
    end_test("speed");
    pulse(1);
    wait_halt(1'b1, 1000, n);
    chk("wait park", 2'b11, {halted, phi});
    chk("wait osc", 2'b11, ens[3:2]);
    pulse(2);
    wait_halt(1'b0, 10, n);
    chk("wait wake", 1'b1, n <= 3);
    end_test("wait");
    reg_wr(8'h02, 8'h00);
    pulse(0);
    wait_halt(1'b1, 1000, n);
    repeat (2) @(posedge core_clk);
    #1;
    chk("stop osc", 4'h0, ens);
    pulse(2);
    wait_halt(1'b0, 20000, n);
    chk("stab wait", 1'b1, n > stab_cycles(LS_HP) - 40 && n < stab_cycles(LS_HP) + 40);
    end_test("stop preset");
    dut_reset(8'h00, 8'h00);
    reg_wr(8'h03, 8'h00);
    reg_wr(8'h04, 8'h00);
    reg_wr(8'h02, 8'h02);
    pulse(0);
    wait_halt(1'b1, 1000, n);
    repeat (2) @(posedge core_clk);
    #1;
    chk("ls kept", 1'b1, ens[3]);
    pulse(2);
    wait_halt(1'b0, 2000, n);
    chk("no preset", 1'b1, n < 256);
    end_test("stop keep");
    print_verdict();
  end
endmodule : tb_top
